// file: hdl/pmx_port_pin_function_mux.sv
`timescale 1ns/1ps
module pmx_port_pin_function_mux (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   // Register port
   input  wire pmx_pkg::pmx_bus_req_t    bus_req,
   output logic [31:0]                   rdata,
   // GPIO controller
   input  wire logic [15:0]              gpio_out,
   input  wire logic [15:0]              gpio_direction_bits,
   output logic [15:0]                   gpio_in,
   // Peripherals
   input  wire pmx_pkg::pmx_periph_out_t periph_out,
   output pmx_pkg::pmx_periph_in_t       periph_in,
   // Port 0 pins 0 to 15
   input  wire logic [15:0]              pin_in,
   output logic [15:0]                   pin_out,
   output logic [15:0]                   pin_oe,
   // Other select registers, for blocks outside
   output logic [31:0]                   sel_high,
   output logic                          debug_port_en,
   output logic                          trace_port_en
);
   import pmx_pkg::*;

   logic [31:0]     sel_low_ff;
   logic [31:0]     sel_high_ff;
   logic [31:0]     trace_sel_ff;
   logic [31:0]     nxt_sel_low;
   logic [31:0]     rdata_ff;
   logic [15:0]     pin_meta_ff;
   logic [15:0]     pin_sync_ff;
   logic [15:0]     pin_out_ff;
   logic [15:0]     pin_oe_ff;
   logic [15:0]     gpio_in_ff;
   logic            debug_en_ff;
   logic            trace_en_ff;
   pmx_periph_in_t  periph_in_ff;
   pmx_periph_in_t  nxt_periph_in;
   logic [3:0]      cand_out [PMX_PINS];
   logic [3:0]      cand_oe  [PMX_PINS];
   logic            wr_low;
   logic            wr_high;
   logic            wr_trace;

   function automatic logic hit(input logic [31:0] sel,
                                input int unsigned n,
                                input logic [1:0]  code);
      return pmx_field(sel, n) == code;
   endfunction

   assign wr_low   = bus_req.wr && bus_req.addr == PMX_ADDR_SEL_LOW;
   assign wr_high  = bus_req.wr && bus_req.addr == PMX_ADDR_SEL_HIGH;
   assign wr_trace = bus_req.wr && bus_req.addr == PMX_ADDR_TRACE;

   // Routing is computed from the value being written so the pins move
   // on the same edge that loads the register
   assign nxt_sel_low = wr_low ? bus_req.wdata : sel_low_ff;

   // Select registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sel_low_ff <= PMX_SEL_LOW_RST;
      end else begin
         sel_low_ff <= nxt_sel_low;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sel_high_ff  <= PMX_SEL_HIGH_RST;
         trace_sel_ff <= PMX_TRACE_RST;
         debug_en_ff  <= 1'b0;
         trace_en_ff  <= 1'b0;
      end else begin
         if (wr_high) begin
            sel_high_ff <= bus_req.wdata;
         end
         if (wr_trace) begin
            trace_sel_ff <= bus_req.wdata;
            debug_en_ff  <= bus_req.wdata[PMX_DEBUG_EN_BIT];
            trace_en_ff  <= bus_req.wdata[PMX_TRACE_EN_BIT];
         end
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_ff <= 32'h00000000;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            PMX_ADDR_SEL_LOW:  rdata_ff <= sel_low_ff;
            PMX_ADDR_SEL_HIGH: rdata_ff <= sel_high_ff;
            PMX_ADDR_TRACE:    rdata_ff <= trace_sel_ff;
            default:           rdata_ff <= 32'h00000000;
         endcase
      end else begin
         rdata_ff <= 32'h00000000;
      end
   end

   // Pins come from outside the clock domain
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_meta_ff <= 16'h0000;
         pin_sync_ff <= 16'h0000;
      end else begin
         pin_meta_ff <= pin_in;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // Candidate drive per pin and function code; reserved codes stay
   // undriven so a bad write can never fight the board
   always_comb begin
      for (int n = 0; n < PMX_PINS; n++) begin
         cand_out[n]    = 4'h0;
         cand_oe[n]     = 4'h0;
         cand_out[n][0] = gpio_out[n];
         cand_oe[n][0]  = gpio_direction_bits[n];
      end
      cand_out[0][1]  = periph_out.uart0_txd;
      cand_oe[0][1]   = 1'b1;
      cand_out[0][2]  = periph_out.pwm[1];
      cand_oe[0][2]   = 1'b1;
      cand_out[1][2]  = periph_out.pwm[3];
      cand_oe[1][2]   = 1'b1;
      // I2C lines are open drain: drive low or release
      cand_oe[2][1]   = periph_out.i2c_scl_pull_low;
      cand_oe[3][1]   = periph_out.i2c_sda_pull_low;
      cand_out[3][2]  = periph_out.t0_match[0];
      cand_oe[3][2]   = 1'b1;
      cand_out[4][1]  = periph_out.spi0_sck;
      cand_oe[4][1]   = periph_out.spi0_sck_oe;
      cand_out[5][1]  = periph_out.spi0_miso;
      cand_oe[5][1]   = periph_out.spi0_miso_oe;
      cand_out[5][2]  = periph_out.t0_match[1];
      cand_oe[5][2]   = 1'b1;
      cand_out[6][1]  = periph_out.spi0_mosi;
      cand_oe[6][1]   = periph_out.spi0_mosi_oe;
      cand_out[7][2]  = periph_out.pwm[2];
      cand_oe[7][2]   = 1'b1;
      cand_out[8][1]  = periph_out.uart1_txd;
      cand_oe[8][1]   = 1'b1;
      cand_out[8][2]  = periph_out.pwm[4];
      cand_oe[8][2]   = 1'b1;
      cand_out[9][2]  = periph_out.pwm[6];
      cand_oe[9][2]   = 1'b1;
      cand_out[10][1] = periph_out.uart1_rts;
      cand_oe[10][1]  = 1'b1;
      cand_out[12][2] = periph_out.t1_match[0];
      cand_oe[12][2]  = 1'b1;
      cand_out[13][1] = periph_out.uart1_dtr;
      cand_oe[13][1]  = 1'b1;
      cand_out[13][2] = periph_out.t1_match[1];
      cand_oe[13][2]  = 1'b1;
   end

   // Pin drive, registered so a rewrite of other fields cannot glitch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_out_ff <= 16'h0000;
         pin_oe_ff  <= 16'h0000;
      end else begin
         for (int n = 0; n < PMX_PINS; n++) begin
            pin_out_ff[n] <= cand_out[n][pmx_field(nxt_sel_low, n)];
            pin_oe_ff[n]  <= cand_oe[n][pmx_field(nxt_sel_low, n)];
         end
      end
   end

   // Input side: a peripheral sees a pin only while its code is selected;
   // otherwise it gets a quiet idle level
   always_comb begin
      nxt_periph_in = PMX_IN_IDLE;
      if (hit(nxt_sel_low, 1, PMX_FN_ALT1)) begin
         nxt_periph_in.uart0_rxd = pin_sync_ff[1];
      end
      if (hit(nxt_sel_low, 2, PMX_FN_ALT1)) begin
         nxt_periph_in.i2c_scl_in = pin_sync_ff[2];
      end
      if (hit(nxt_sel_low, 3, PMX_FN_ALT1)) begin
         nxt_periph_in.i2c_sda_in = pin_sync_ff[3];
      end
      if (hit(nxt_sel_low, 4, PMX_FN_ALT1)) begin
         nxt_periph_in.spi0_sck_in = pin_sync_ff[4];
      end
      if (hit(nxt_sel_low, 5, PMX_FN_ALT1)) begin
         nxt_periph_in.spi0_miso_in = pin_sync_ff[5];
      end
      if (hit(nxt_sel_low, 6, PMX_FN_ALT1)) begin
         nxt_periph_in.spi0_mosi_in = pin_sync_ff[6];
      end
      if (hit(nxt_sel_low, 7, PMX_FN_ALT1)) begin
         nxt_periph_in.spi0_ssel_in = pin_sync_ff[7];
      end
      if (hit(nxt_sel_low, 9, PMX_FN_ALT1)) begin
         nxt_periph_in.uart1_rxd = pin_sync_ff[9];
      end
      if (hit(nxt_sel_low, 11, PMX_FN_ALT1)) begin
         nxt_periph_in.uart1_cts = pin_sync_ff[11];
      end
      if (hit(nxt_sel_low, 12, PMX_FN_ALT1)) begin
         nxt_periph_in.uart1_dsr = pin_sync_ff[12];
      end
      if (hit(nxt_sel_low, 14, PMX_FN_ALT1)) begin
         nxt_periph_in.uart1_dcd = pin_sync_ff[14];
      end
      if (hit(nxt_sel_low, 15, PMX_FN_ALT1)) begin
         nxt_periph_in.uart1_ri = pin_sync_ff[15];
      end
      nxt_periph_in.t0_capture[0] = hit(nxt_sel_low, 2, PMX_FN_ALT2)
                                    & pin_sync_ff[2];
      nxt_periph_in.t0_capture[1] = hit(nxt_sel_low, 4, PMX_FN_ALT2)
                                    & pin_sync_ff[4];
      nxt_periph_in.t0_capture[2] = hit(nxt_sel_low, 6, PMX_FN_ALT2)
                                    & pin_sync_ff[6];
      nxt_periph_in.t1_capture[0] = hit(nxt_sel_low, 10, PMX_FN_ALT2)
                                    & pin_sync_ff[10];
      nxt_periph_in.t1_capture[1] = hit(nxt_sel_low, 11, PMX_FN_ALT2)
                                    & pin_sync_ff[11];
      // Two pins may feed one interrupt line; they are ORed
      nxt_periph_in.external_interrupt[0] =
         hit(nxt_sel_low, 1, PMX_FN_ALT3) & pin_sync_ff[1];
      nxt_periph_in.external_interrupt[1] =
         (hit(nxt_sel_low, 3, PMX_FN_ALT3) & pin_sync_ff[3]) |
         (hit(nxt_sel_low, 14, PMX_FN_ALT2) & pin_sync_ff[14]);
      nxt_periph_in.external_interrupt[2] =
         (hit(nxt_sel_low, 7, PMX_FN_ALT3) & pin_sync_ff[7]) |
         (hit(nxt_sel_low, 15, PMX_FN_ALT2) & pin_sync_ff[15]);
      nxt_periph_in.external_interrupt[3] =
         hit(nxt_sel_low, 9, PMX_FN_ALT3) & pin_sync_ff[9];
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         periph_in_ff <= PMX_IN_IDLE;
         gpio_in_ff   <= 16'h0000;
      end else begin
         periph_in_ff <= nxt_periph_in;
         // GPIO always reads back the pin level, whatever the selection
         gpio_in_ff   <= pin_sync_ff;
      end
   end

   assign rdata         = rdata_ff;
   assign pin_out       = pin_out_ff;
   assign pin_oe        = pin_oe_ff;
   assign periph_in     = periph_in_ff;
   assign gpio_in       = gpio_in_ff;
   assign sel_high      = sel_high_ff;
   assign debug_port_en = debug_en_ff;
   assign trace_port_en = trace_en_ff;

endmodule

// file: shared/pmx_pkg.sv
// Notes on behaviour
// - Select registers steer each muxed pin to exactly one function.
// - Low select: sixteen 2-bit fields, pin n at bits 2n+1:2n, reset GPIO.
// - Pin 0: UART0 TxD, pulse 1, none. Pin 1: UART0 RxD, pulse 3, EXTINT0.
// - Pin 2: I2C SCL, T0 capture 0. Pin 3: I2C SDA, T0 match 0, EXTINT1.
// - Pin 4: SPI0 SCK, T0 capture 1. Pin 5: SPI0 MISO, T0 match 1.
// - Pin 6: SPI0 MOSI, T0 capture 2. Pin 7: SPI0 SSEL, pulse 2, EXTINT2.
// - Pins 8-10: UART1 TxD/pulse 4, RxD/pulse 6/EXTINT3, RTS/T1 capture 0.
// - Pins 11-15: UART1 modem lines on 01; timer 1 and EXTINT on 10.
// - Direction bit counts only under GPIO; else the peripheral sets it.
// - Unrouted enabled peripherals see no guaranteed behaviour.
// - Three RW select registers at fixed addresses; reads give last write.
package pmx_pkg;

   localparam int unsigned PMX_PINS          = 16;
   localparam int unsigned PMX_FIELD_W       = 2;

   localparam logic [31:0] PMX_ADDR_SEL_LOW  = 32'he002c000;
   localparam logic [31:0] PMX_ADDR_SEL_HIGH = 32'he002c004;
   localparam logic [31:0] PMX_ADDR_TRACE    = 32'he002c014;

   localparam logic [31:0] PMX_SEL_LOW_RST   = 32'h00000000;
   localparam logic [31:0] PMX_SEL_HIGH_RST  = 32'h00000000;
   localparam logic [31:0] PMX_TRACE_RST     = 32'h00000000;
   localparam int unsigned PMX_DEBUG_EN_BIT  = 2;
   localparam int unsigned PMX_TRACE_EN_BIT  = 3;

   localparam logic [1:0]  PMX_FN_GPIO       = 2'h0;
   localparam logic [1:0]  PMX_FN_ALT1       = 2'h1;
   localparam logic [1:0]  PMX_FN_ALT2       = 2'h2;
   localparam logic [1:0]  PMX_FN_ALT3       = 2'h3;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pmx_bus_req_t;

   // Outputs the peripherals offer to the pins
   typedef struct packed {
      logic       uart0_txd;
      logic       uart1_txd;
      logic       uart1_rts;
      logic       uart1_dtr;
      logic       i2c_scl_pull_low;
      logic       i2c_sda_pull_low;
      logic       spi0_sck;
      logic       spi0_sck_oe;
      logic       spi0_miso;
      logic       spi0_miso_oe;
      logic       spi0_mosi;
      logic       spi0_mosi_oe;
      logic [1:0] t0_match;
      logic [1:0] t1_match;
      logic [6:1] pwm;
   } pmx_periph_out_t;

   // Pin levels handed to the peripherals
   typedef struct packed {
      logic       uart0_rxd;
      logic       uart1_rxd;
      logic       uart1_cts;
      logic       uart1_dsr;
      logic       uart1_dcd;
      logic       uart1_ri;
      logic       i2c_scl_in;
      logic       i2c_sda_in;
      logic       spi0_sck_in;
      logic       spi0_miso_in;
      logic       spi0_mosi_in;
      logic       spi0_ssel_in;
      logic [2:0] t0_capture;
      logic [1:0] t1_capture;
      logic [3:0] external_interrupt;
   } pmx_periph_in_t;

   // Idle level of every peripheral input when no pin feeds it
   localparam pmx_periph_in_t PMX_IN_IDLE = '{
      uart0_rxd: 1'b1, uart1_rxd: 1'b1, uart1_cts: 1'b1, uart1_dsr: 1'b1,
      uart1_dcd: 1'b1, uart1_ri: 1'b1, i2c_scl_in: 1'b1, i2c_sda_in: 1'b1,
      spi0_sck_in: 1'b0, spi0_miso_in: 1'b0, spi0_mosi_in: 1'b0,
      spi0_ssel_in: 1'b1, t0_capture: 3'h0, t1_capture: 2'h0,
      external_interrupt: 4'h0};

   function automatic logic [1:0] pmx_field(input logic [31:0] sel,
                                            input int unsigned n);
      return sel[PMX_FIELD_W*n +: PMX_FIELD_W];
   endfunction

endpackage

// file: verification/pmx_pin_mux_monitor.sv
`timescale 1ns/1ps
module pmx_pin_mux_monitor (
   // Clock and reset
   input wire logic                     clk,
   input wire logic                     sys_rst,
   // Register port
   input wire pmx_pkg::pmx_bus_req_t    bus_req,
   input wire logic [31:0]              rdata,
   // Pin side
   input wire logic [15:0]              gpio_out,
   input wire logic [15:0]              gpio_direction_bits,
   input wire pmx_pkg::pmx_periph_out_t periph_out,
   input wire pmx_pkg::pmx_periph_in_t  periph_in,
   input wire logic [15:0]              pin_in,
   input wire logic [15:0]              pin_out,
   input wire logic [15:0]              pin_oe
);
   import pmx_pkg::*;
   logic [31:0] low_ff;
   logic        rd_bad;
   // Shadow of the low select register
   always_ff @(posedge clk) begin
      if (sys_rst)
         low_ff <= PMX_SEL_LOW_RST;
      else if (bus_req.wr && bus_req.addr == PMX_ADDR_SEL_LOW)
         low_ff <= bus_req.wdata;
   end
   assign rd_bad = bus_req.rd && bus_req.addr != PMX_ADDR_SEL_LOW &&
                   bus_req.addr != PMX_ADDR_SEL_HIGH &&
                   bus_req.addr != PMX_ADDR_TRACE;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_read_idle: assert property (
      !$past(bus_req.rd) |-> rdata == 32'h0)
      else $error("Read data not zero outside read slot");
   chk_read_back: assert property (
      bus_req.rd && bus_req.addr == PMX_ADDR_SEL_LOW |=>
      rdata == $past(low_ff))
      else $error("Low select readback wrong");
   chk_read_unmapped: assert property (
      rd_bad |=> rdata == 32'h0)
      else $error("Unmapped read not zero");
   for (genvar n = 0; n < 16; n++) begin : g_pin
      chk_gpio_dir: assert property (
         !$past(sys_rst) && low_ff[2*n +: 2] == PMX_FN_GPIO |->
         pin_oe[n] == $past(gpio_direction_bits[n]) &&
         pin_out[n] == $past(gpio_out[n]))
         else $error("GPIO pin not following its bits");
   end
   chk_uart0_tx: assert property (
      low_ff[1:0] == PMX_FN_ALT1 |->
      pin_oe[0] && pin_out[0] == $past(periph_out.uart0_txd))
      else $error("Pin 0 not carrying uart transmit");
   chk_pwm_one: assert property (
      low_ff[1:0] == PMX_FN_ALT2 |->
      pin_oe[0] && pin_out[0] == $past(periph_out.pwm[1]))
      else $error("Pin 0 not carrying pulse output");
   chk_reserved_off: assert property (
      low_ff[1:0] == PMX_FN_ALT3 |-> !pin_oe[0] && !pin_out[0])
      else $error("Reserved code drives pin 0");
   chk_i2c_clock: assert property (
      low_ff[5:4] == PMX_FN_ALT1 |-> !pin_out[2] &&
      pin_oe[2] == $past(periph_out.i2c_scl_pull_low))
      else $error("Pin 2 not open drain clock");
   chk_rx_sync: assert property (
      (low_ff[3:2] == PMX_FN_ALT1) [*4] |->
      periph_in.uart0_rxd == $past(pin_in[1], 3))
      else $error("Receive line not routed from pin 1");
   chk_external_interrupt_3_route: assert property (
      (low_ff[19:18] == PMX_FN_ALT3) [*4] |->
      periph_in.external_interrupt[3] == $past(pin_in[9], 3))
      else $error("Interrupt 3 not routed from pin 9");
   cover property (bus_req.wr && bus_req.addr == PMX_ADDR_SEL_LOW);
   cover property (rd_bad);
   cover property ((low_ff[19:18] == PMX_FN_ALT3) [*4]);
endmodule
bind pmx_port_pin_function_mux pmx_pin_mux_monitor pmx_pin_mux_monitor_inst (
   .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
   .gpio_out(gpio_out), .gpio_direction_bits(gpio_direction_bits),
   .periph_out(periph_out), .periph_in(periph_in), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe));

// file: verification/pmx_pin_far_model.sv
`timescale 1ns/1ps
module pmx_pin_far_model (
   // Device pins
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe,
   output logic [15:0]      pin_in,
   // Level the outside world puts on released pins
   input  wire logic [15:0] ext_level
);
   // Released pin shows the outside level, never a stale drive
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// file: verification/pmx_port_pin_function_mux_bench.sv
`timescale 1ns/1ps
module pmx_port_pin_function_mux_bench;
   import pmx_pkg::*;
   logic            clk;
   logic            sys_rst;
   pmx_bus_req_t    req;
   logic [31:0]     rdata;
   logic [15:0]     gpio_out;
   logic [15:0]     gpio_dir;
   logic [15:0]     gpio_in;
   pmx_periph_out_t pout;
   pmx_periph_in_t  pin_fn;
   pmx_periph_in_t  exp_in;
   logic [15:0]     pin_in;
   logic [15:0]     pin_out;
   logic [15:0]     pin_oe;
   logic [15:0]     ext;
   logic [31:0]     sel_high;
   logic            dbg_en;
   logic            trc_en;
   int              miscompares;
   int              num_checks;
   int              cycles;
   pmx_port_pin_function_mux pmx_port_pin_function_mux_inst (
      .clk(clk), .sys_rst(sys_rst), .bus_req(req), .rdata(rdata),
      .gpio_out(gpio_out), .gpio_direction_bits(gpio_dir),
      .gpio_in(gpio_in), .periph_out(pout), .periph_in(pin_fn),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .sel_high(sel_high), .debug_port_en(dbg_en),
      .trace_port_en(trc_en));
   pmx_pin_far_model pmx_pin_far_model_inst (
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
      .ext_level(ext));
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
      #1;
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1;
      cmp(rdata, exp);
   endtask
   // Rewrite the low select and look at the pins just after the edge that loads it
   task automatic pins(input logic [31:0] s, input logic [15:0] oe,
                       input logic [15:0] out);
      wr(PMX_ADDR_SEL_LOW, s);
      cmp({16'h0, pin_oe}, {16'h0, oe});
      cmp({16'h0, pin_out}, {16'h0, out});
   endtask
   // Outside level, then wait out the input synchroniser
   task automatic ins(input logic [15:0] lvl, input logic [31:0] exp);
      @(posedge clk);
      ext <= lvl;
      repeat (4) @(posedge clk);
      #1;
      cmp(32'(pin_fn), exp);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      sys_rst     = 1'b1;
      req         = '0;
      gpio_out    = 16'h0ff0;
      gpio_dir    = 16'h5a3c;
      pout        = '0;
      ext         = 16'h0;
      miscompares = 0;
      num_checks  = 0;
      cycles      = 0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk(PMX_ADDR_SEL_LOW, PMX_SEL_LOW_RST);
      rd_chk(PMX_ADDR_SEL_HIGH, PMX_SEL_HIGH_RST);
      rd_chk(PMX_ADDR_TRACE, PMX_TRACE_RST);
      wr(PMX_ADDR_SEL_HIGH, 32'h8765_4321);
      wr(PMX_ADDR_TRACE, 32'h0000_000c);
      wr(32'he002_c008, 32'hffff_ffff);
      rd_chk(PMX_ADDR_SEL_HIGH, 32'h8765_4321);
      rd_chk(PMX_ADDR_TRACE, 32'h0000_000c);
      rd_chk(32'he002_c008, 32'h0);
      cmp(sel_high, 32'h8765_4321);
      cmp({30'h0, dbg_en, trc_en}, 32'h3);
      // One enable alone, so swapped enable wires show up
      wr(PMX_ADDR_TRACE, 32'h0000_0004);
      cmp({30'h0, dbg_en, trc_en}, 32'h2);
      wr(PMX_ADDR_SEL_LOW, 32'h1b6c_93e4);
      rd_chk(PMX_ADDR_SEL_LOW, 32'h1b6c_93e4);
      $display("Test registers finished");
      pins(32'h0, 16'h5a3c, 16'h0ff0);
      ins(16'hffff, 32'(PMX_IN_IDLE));
      cmp({16'h0, gpio_in}, 32'h0000_aff3);
      $display("Test gpio finished");
      @(posedge clk);
      pout <= '1;
      pins(32'h5555_5555, 16'h257d, 16'h2571);
      pins(32'haaaa_aaaa, 16'h33ab, 16'h33ab);
      pins(32'hffff_ffff, 16'h0, 16'h0);
      @(posedge clk);
      pout <= '0;
      // Pins mapped before the far side starts toggling them
      pins(32'h5555_5555, 16'h2501, 16'h0);
      exp_in = '0;
      exp_in.uart1_rxd = 1'b1;
      exp_in.uart1_ri = 1'b1;
      ins(16'h8200, 32'(exp_in));
      pins(32'haaaa_aaaa, 16'h33ab, 16'h0);
      exp_in = PMX_IN_IDLE;
      exp_in.t0_capture = 3'h7;
      exp_in.t1_capture = 2'h2;
      exp_in.external_interrupt = 4'h6;
      ins(16'hc854, 32'(exp_in));
      pins(32'hffff_ffff, 16'h0, 16'h0);
      exp_in.t0_capture = 3'h0;
      exp_in.t1_capture = 2'h0;
      exp_in.external_interrupt = 4'h9;
      ins(16'h0202, 32'(exp_in));
      exp_in.external_interrupt = 4'hf;
      ins(16'h028a, 32'(exp_in));
      $display("Test routing finished");
      // Reset in mid-run must put every pin back to GPIO
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk(PMX_ADDR_SEL_LOW, PMX_SEL_LOW_RST);
      cmp({16'h0, pin_oe}, 32'h0000_5a3c);
      $display("Test second reset finished");
      test_done();
   end
endmodule
